// file: verification/rffl_flag_latches_tb_top.sv
// self-checking bench for the fault flag latches
`timescale 1ns/1ps
module rffl_flag_latches_tb_top;
   import rffl_pkg::*;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [3:0] pin [4] = '{default: 4'h0};
   logic [3:0] running = 4'h0;
   logic [3:0] ramp_end = 4'h0;
   logic [3:0] start_up = 4'h0;
   logic wr, rd, rvalid, sum12, sum34;
   logic [7:0] addr, wdata, rdata;
   int num_errors = 0;
   int n_compared = 0;
   localparam logic [7:0] B12 = RFFL_OFFS_ONE_TWO;
   localparam logic [7:0] B34 = RFFL_OFFS_THREE_FOUR;
   always #2 i_clk = ~i_clk;
   rffl_host_model host (.i_clk(i_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
      .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));
   rffl_flag_latches dut (.i_clk(i_clk), .i_reset(i_reset), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .o_reg_rvalid(rvalid), .i_overvoltage(pin[RFFL_FLD_OV]),
      .i_undervoltage(pin[RFFL_FLD_UV]), .i_current_limit(pin[RFFL_FLD_ILIM]),
      .i_below_sc_threshold(pin[RFFL_FLD_SC]), .i_reg_running(running),
      .i_ramp_end(ramp_end), .i_start_up(start_up),
      .o_regs_one_two_summary_flag(sum12), .o_regs_three_four_summary_flag(sum34));
   task automatic stop_test;
      if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : cyc
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // reads a bank and checks its summary level alongside
   task automatic expect_bank(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host.rd(a, d, ok);
      if (!ok) begin
         num_errors++;
         $display("BAD read_valid expected 1 seen 0");
         stop_test();
      end
      check("flags", exp, d);
      if (a == B12) check("summary12", {7'h00, |exp}, {7'h00, sum12});
      if (a == B34) check("summary34", {7'h00, |exp}, {7'h00, sum34});
   endtask : expect_bank
   task automatic t_reset;
      expect_bank(B12, RFFL_FLAGS_RESET);
      expect_bank(B34, RFFL_FLAGS_RESET);
      expect_bank(8'h5E, RFFL_READ_UNMAPPED);
   endtask : t_reset
   task automatic t_events;
      int fl[3] = '{RFFL_FLD_OV, RFFL_FLD_UV, RFFL_FLD_ILIM};
      logic [7:0] a, m;
      for (int r = 0; r < 4; r++) foreach (fl[i]) begin
         a = (r < 2) ? B12 : B34;
         m = 8'h01 << (fl[i] + 4 * (r % 2));
         pin[fl[i]][r] = 1'b1;
         cyc(6);
         expect_bank(a, m);
         pin[fl[i]][r] = 1'b0;
         cyc(6);
         expect_bank(a, m);
         host.wr(a, m);
         expect_bank(a, 8'h00);
      end
   endtask : t_events
   // short-circuit paths on every regulator, with the quiet cases in between
   task automatic t_short;
      logic [7:0] a, m;
      for (int r = 0; r < 4; r++) begin
         a = (r < 2) ? B12 : B34;
         m = 8'h01 << (RFFL_FLD_SC + 4 * (r % 2));
         pin[RFFL_FLD_SC][r] = 1'b1;
         cyc(6);
         expect_bank(a, 8'h00);
         running[r] = 1'b1;
         cyc(2);
         running[r] = 1'b0;
         expect_bank(a, m);
         host.wr(a, m);
         ramp_end[r] = 1'b1;
         cyc(1);
         ramp_end[r] = 1'b0;
         expect_bank(a, m);
         host.wr(a, m);
         start_up[r] = 1'b1;
         cyc(1);
         start_up[r] = 1'b0;
         pin[RFFL_FLD_SC][r] = 1'b0;
         cyc(6);
         expect_bank(a, 8'h00);
         ramp_end[r] = 1'b1;
         cyc(1);
         ramp_end[r] = 1'b0;
         expect_bank(a, 8'h00);
         start_up[r] = 1'b1;
         cyc(1);
         start_up[r] = 1'b0;
         expect_bank(a, m);
         host.wr(a, m);
         expect_bank(a, 8'h00);
      end
   endtask : t_short
   task automatic t_clear_rules;
      pin[RFFL_FLD_OV][1:0] = 2'b11;
      cyc(6);
      host.wr(B12, 8'h10);
      expect_bank(B12, 8'h11);
      pin[RFFL_FLD_OV][1:0] = 2'b00;
      cyc(6);
      host.wr(B12, 8'h00);
      expect_bank(B12, 8'h11);
      host.wr(B12, 8'h01);
      expect_bank(B12, 8'h10);
      host.wr(8'h5E, 8'hFF);
      expect_bank(B12, 8'h10);
      host.wr(B34, 8'h10);
      expect_bank(B12, 8'h10);
      host.wr(B12, 8'h10);
      expect_bank(B12, 8'h00);
      pin[RFFL_FLD_ILIM][3] = 1'b1;
      cyc(6);
      host.wr(B34, 8'h80);
      expect_bank(B34, 8'h80);
      pin[RFFL_FLD_ILIM][3] = 1'b0;
      cyc(6);
      host.wr(B34, 8'h80);
      expect_bank(B34, 8'h00);
   endtask : t_clear_rules
   initial begin
      cyc(10);
      i_reset = 1'b0;
      t_reset();
      t_events();
      t_short();
      t_clear_rules();
      stop_test();
   end
endmodule : rffl_flag_latches_tb_top

// file: verification/rffl_host_model.sv
// host side model driving the decoded register strobes
`timescale 1ns/1ps
module rffl_host_model (
   // clock
   input wire logic i_clk,
   // strobes toward the block
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata,
   // answer from the block
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   // ones clear flags, so idle data is inverted rather than left stale
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_clk);
      #1 o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
      @(posedge i_clk);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      d = 8'h00;
      o_addr = a;
      o_rd = 1'b1;
      @(posedge i_clk);
      #1 o_rd = 1'b0;
      o_addr = ~a;
      for (int n = 0; n < 4 && !ok; n++) begin
         if (i_rvalid === 1'b1) begin
            ok = 1'b1;
            d = i_rdata;
         end else begin
            @(posedge i_clk);
            #1;
         end
      end
      // one idle edge, so a following request never re-raises the strobe in this step
      @(posedge i_clk);
      #1;
   endtask : rd
endmodule : rffl_host_model

// file: verilog/rffl_flag_latches.sv
// latched fault flags for four step-down regulators
// Summary of operation
// RL1 - flags for regulators 1,2 at 0x5C, reset zero
// RL2 - flags for regulators 3,4 at 0x5D, reset zero
// RL3 - over-voltage event sets and holds flag
// RL4 - under-voltage event sets and holds flag
// RL5 - current-limit event sets and holds flag
// RL6 - output below threshold while running sets short-circuit
// RL7 - threshold not reached after ramp sets short-circuit
// RL8 - output above threshold before start sets short-circuit
// RL9 - flags hold until host writes one
// RL10 - summary bit high while its bank nonzero
// RL11 - write zero keeps flag; event beats clear
`timescale 1ns/1ps
module rffl_flag_latches (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // serial register interface, decoded
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [rffl_pkg::RFFL_ADDR_W-1:0] i_reg_addr,
   input wire logic [rffl_pkg::RFFL_DATA_W-1:0] i_reg_wdata,
   output logic [rffl_pkg::RFFL_DATA_W-1:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // analog comparators, asynchronous
   input wire logic [rffl_pkg::RFFL_NUM_REG-1:0] i_overvoltage,
   input wire logic [rffl_pkg::RFFL_NUM_REG-1:0] i_undervoltage,
   input wire logic [rffl_pkg::RFFL_NUM_REG-1:0] i_current_limit,
   input wire logic [rffl_pkg::RFFL_NUM_REG-1:0] i_below_sc_threshold,
   // regulator sequencer, same clock
   input wire logic [rffl_pkg::RFFL_NUM_REG-1:0] i_reg_running,
   input wire logic [rffl_pkg::RFFL_NUM_REG-1:0] i_ramp_end,
   input wire logic [rffl_pkg::RFFL_NUM_REG-1:0] i_start_up,
   // bank summaries
   output logic o_regs_one_two_summary_flag,
   output logic o_regs_three_four_summary_flag
);
   import rffl_pkg::*;

   localparam int NPIN = 4 * RFFL_NUM_REG;

   rffl_sync_if #(.W(NPIN)) sif ();

   assign sif.raw = {i_below_sc_threshold, i_current_limit, i_undervoltage, i_overvoltage};

   rffl_sync #(.W(NPIN)) u_sync (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .sif(sif)
   );

   logic [RFFL_NUM_REG-1:0] ov_s;
   logic [RFFL_NUM_REG-1:0] uv_s;
   logic [RFFL_NUM_REG-1:0] ilim_s;
   logic [RFFL_NUM_REG-1:0] below_s;
   assign {below_s, ilim_s, uv_s, ov_s} = sif.clean;

   logic [2*RFFL_DATA_W-1:0] evt;
   logic [RFFL_DATA_W-1:0] flags [RFFL_NUM_BANK];
   logic [RFFL_DATA_W-1:0] next_flags [RFFL_NUM_BANK];
   logic [RFFL_DATA_W-1:0] clr [RFFL_NUM_BANK];

   // comparator levels keep setting while active, so a clear during a fault does not stick
   genvar r;
   generate
      for (r = 0; r < RFFL_NUM_REG; r++) begin : g_evt
         assign evt[4*r+RFFL_FLD_OV] = ov_s[r]; // RL3
         assign evt[4*r+RFFL_FLD_UV] = uv_s[r]; // RL4
         assign evt[4*r+RFFL_FLD_ILIM] = ilim_s[r]; // RL5
         assign evt[4*r+RFFL_FLD_SC] = (i_reg_running[r] & below_s[r]) // RL6
            | (i_ramp_end[r] & below_s[r]) // RL7
            | (i_start_up[r] & ~below_s[r]); // RL8
      end
   endgenerate

   assign clr[0] = (i_reg_wr && i_reg_addr == RFFL_OFFS_ONE_TWO) ? i_reg_wdata : '0; // RL1
   assign clr[1] = (i_reg_wr && i_reg_addr == RFFL_OFFS_THREE_FOUR) ? i_reg_wdata : '0; // RL2

   always_comb begin
      for (int b = 0; b < RFFL_NUM_BANK; b++) begin
         // set wins over clear, zero bits of the write clear nothing
         next_flags[b] = (flags[b] & ~clr[b]) | evt[RFFL_DATA_W*b +: RFFL_DATA_W]; // RL9 RL11
      end
   end

   always_ff @(posedge i_clk) begin
      for (int b = 0; b < RFFL_NUM_BANK; b++) begin
         if (i_reset) begin
            flags[b] <= RFFL_FLAGS_RESET; // RL1 RL2
         end else begin
            flags[b] <= next_flags[b];
         end
      end
   end

   // summaries follow the next value so they never lag the flags by a cycle
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_regs_one_two_summary_flag <= 1'b0;
         o_regs_three_four_summary_flag <= 1'b0;
      end else begin
         o_regs_one_two_summary_flag <= |next_flags[0]; // RL10
         o_regs_three_four_summary_flag <= |next_flags[1]; // RL10
      end
   end

   // read returns the flags as they stood at the read edge
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_reg_rdata <= RFFL_READ_UNMAPPED;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (!i_reg_rd) begin
            o_reg_rdata <= RFFL_READ_UNMAPPED;
         end else if (i_reg_addr == RFFL_OFFS_ONE_TWO) begin
            o_reg_rdata <= flags[0]; // RL9
         end else if (i_reg_addr == RFFL_OFFS_THREE_FOUR) begin
            o_reg_rdata <= flags[1]; // RL9
         end else begin
            o_reg_rdata <= RFFL_READ_UNMAPPED;
         end
      end
   end

   logic [7:0] f12;
   logic [7:0] f34;
   assign f12 = flags[0];
   assign f34 = flags[1];

   bank_one_reset_a: assert property (@(posedge i_clk) i_reset |=> f12 == 8'h00) // RL1
      else $error("bank one not zero after reset");
   bank_two_reset_a: assert property (@(posedge i_clk) i_reset |=> f34 == 8'h00) // RL2
      else $error("bank two not zero after reset");
   ov_sets_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL3
      ov_s[0] |=> f12[0] && o_regs_one_two_summary_flag)
      else $error("over-voltage did not set flag");
   uv_sets_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL4
      uv_s[2] |=> f34[1])
      else $error("under-voltage did not set flag");
   ilim_sets_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL5
      ilim_s[1] |=> f12[7])
      else $error("current limit did not set flag");
   sc_run_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL6
      i_reg_running[0] && below_s[0] |=> f12[2])
      else $error("short while running not flagged");
   sc_ramp_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL7
      i_ramp_end[2] && below_s[2] |=> f34[2])
      else $error("ramp timeout not flagged");
   sc_prestart_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL8
      i_start_up[3] && !below_s[3] |=> f34[6])
      else $error("pre-start high output not flagged");
   w1c_clear_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL9
      i_reg_wr && i_reg_addr == 8'h5C && i_reg_wdata[0] && !ov_s[0] |=> !f12[0])
      else $error("write one did not clear flag");
   flag_hold_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL9
      f34[5] && !(i_reg_wr && i_reg_addr == 8'h5D && i_reg_wdata[5]) |=> f34[5])
      else $error("flag dropped without clear");
   summary_match_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL10
      o_regs_three_four_summary_flag == (f34 != 8'h00))
      else $error("summary does not match bank");
   set_wins_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL11
      ov_s[1] && i_reg_wr && i_reg_addr == 8'h5C && i_reg_wdata[4] |=> f12[4])
      else $error("clear beat a fault event");
   zero_write_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL11
      i_reg_wr && i_reg_addr == 8'h5C && i_reg_wdata == 8'h00 |=> f12 == ($past(f12) | $past(evt[7:0])))
      else $error("zero write changed flags");

   summary_one_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL10
      o_regs_one_two_summary_flag == (f12 != 8'h00))
      else $error("summary does not match bank one");
   w1c_two_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL9
      i_reg_wr && i_reg_addr == RFFL_OFFS_THREE_FOUR && i_reg_wdata[7] && !ilim_s[3] |=> !f34[7])
      else $error("write one did not clear bank two flag");

   // read data is the flag value at the read edge, zero otherwise
   read_one_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL9
      i_reg_rd && i_reg_addr == RFFL_OFFS_ONE_TWO
      |=> o_reg_rvalid && o_reg_rdata == $past(f12))
      else $error("bank one read wrong");
   read_two_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL9
      i_reg_rd && i_reg_addr == RFFL_OFFS_THREE_FOUR
      |=> o_reg_rvalid && o_reg_rdata == $past(f34))
      else $error("bank two read wrong");
   read_idle_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL9
      !i_reg_rd |=> !o_reg_rvalid && o_reg_rdata == RFFL_READ_UNMAPPED)
      else $error("read data not idle");
   stray_write_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL1 RL2
      i_reg_wr && i_reg_addr != RFFL_OFFS_ONE_TWO && i_reg_addr != RFFL_OFFS_THREE_FOUR
      && evt == '0 |=> f12 == $past(f12) && f34 == $past(f34))
      else $error("unmapped write changed flags");

   // each regulator's four fields land in its own nibble of its own bank
   generate
      for (r = 0; r < RFFL_NUM_REG; r++) begin : g_chk
         ov_lands_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL3
            ov_s[r] |=> flags[r/2][4*(r%2)+RFFL_FLD_OV])
            else $error("over-voltage flag not set");
         uv_lands_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL4
            uv_s[r] |=> flags[r/2][4*(r%2)+RFFL_FLD_UV])
            else $error("under-voltage flag not set");
         ilim_lands_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL5
            ilim_s[r] |=> flags[r/2][4*(r%2)+RFFL_FLD_ILIM])
            else $error("current limit flag not set");
         sc_lands_a: assert property (@(posedge i_clk) disable iff (i_reset) // RL6 RL7 RL8
            ((i_reg_running[r] || i_ramp_end[r]) && below_s[r])
            || (i_start_up[r] && !below_s[r]) |=> flags[r/2][4*(r%2)+RFFL_FLD_SC])
            else $error("short-circuit flag not set");
      end
   endgenerate

   set_then_clear_c: cover property (@(posedge i_clk) disable iff (i_reset)
      o_regs_one_two_summary_flag ##[1:20] !o_regs_one_two_summary_flag);
   read_flags_c: cover property (@(posedge i_clk) disable iff (i_reset)
      o_reg_rvalid && o_reg_rdata != 8'h00);
   collide_c: cover property (@(posedge i_clk) disable iff (i_reset)
      ov_s[1] && i_reg_wr && i_reg_addr == 8'h5C && i_reg_wdata[4]);
   prestart_c: cover property (@(posedge i_clk) disable iff (i_reset)
      i_start_up[3] && !below_s[3]);
   stray_read_c: cover property (@(posedge i_clk) disable iff (i_reset)
      i_reg_rd && i_reg_addr != RFFL_OFFS_ONE_TWO && i_reg_addr != RFFL_OFFS_THREE_FOUR);
endmodule : rffl_flag_latches

// file: verilog/rffl_pkg.sv
// constants for the regulator fault flag latches
package rffl_pkg;
   localparam int RFFL_ADDR_W = 8;
   localparam int RFFL_DATA_W = 8;
   localparam int RFFL_NUM_REG = 4;
   localparam int RFFL_NUM_BANK = 2;
   localparam int RFFL_FIELDS = 4;
   localparam logic [7:0] RFFL_OFFS_ONE_TWO = 8'h5C;
   localparam logic [7:0] RFFL_OFFS_THREE_FOUR = 8'h5D;
   localparam logic [7:0] RFFL_FLAGS_RESET = 8'h00;
   localparam logic [7:0] RFFL_READ_UNMAPPED = 8'h00;
   // field position inside a regulator's nibble
   localparam int RFFL_FLD_OV = 0;
   localparam int RFFL_FLD_UV = 1;
   localparam int RFFL_FLD_SC = 2;
   localparam int RFFL_FLD_ILIM = 3;
   // synchroniser depth for comparator pins
   localparam int RFFL_SYNC_DEPTH = 3;
endpackage : rffl_pkg

// file: verilog/rffl_sync.sv
// three-stage synchroniser with agreement filter for comparator pins
`timescale 1ns/1ps
module rffl_sync #(
   parameter int W = 16
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // raw in, filtered out
   rffl_sync_if.sync sif
);
   import rffl_pkg::*;

   logic [W-1:0] stage [RFFL_SYNC_DEPTH];
   logic [W-1:0] filt;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         for (int s = 0; s < RFFL_SYNC_DEPTH; s++) begin
            stage[s] <= '0;
         end
      end else begin
         stage[0] <= sif.raw;
         for (int s = 1; s < RFFL_SYNC_DEPTH; s++) begin
            stage[s] <= stage[s-1];
         end
      end
   end

   // a bit only moves once stages two and three agree, so one-cycle glitches die here
   genvar b;
   generate
      for (b = 0; b < W; b++) begin : g_filt
         always_ff @(posedge i_clk) begin
            if (i_reset) begin
               filt[b] <= 1'b0;
            end else if (stage[1][b] == stage[2][b]) begin
               filt[b] <= stage[2][b];
            end
         end
      end
   endgenerate

   assign sif.clean = filt;
endmodule : rffl_sync

// file: verilog/rffl_sync_if.sv
// carrier between the flag block and its comparator synchroniser
`timescale 1ns/1ps
interface rffl_sync_if #(
   parameter int W = 16
);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport src (output raw, input clean);
   modport sync (input raw, output clean);
endinterface : rffl_sync_if
